//--- core/sfp_pkg.sv
// Constants, types and command codes shared by the flash command interpreter.
package sfp_pkg;
  localparam logic [7:0] CMD_OCTAL_READ = 8'hE3;
  localparam logic [7:0] CMD_QUAD_READ = 8'hEB;
  localparam logic [7:0] CMD_WORD_READ = 8'hE7;
  localparam logic [7:0] CMD_WRAP_SET = 8'h77;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
  localparam logic [7:0] CMD_QUAD_PROG = 8'h32;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h20;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [5:0] WRAP_FRAME_BITS = 6'h20;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] DUMMY_QUAD_READ = 6'h10;
  localparam logic [5:0] DUMMY_WORD_READ = 6'h08;
  localparam logic [5:0] DUMMY_OCTAL_READ = 6'h00;
  localparam logic [1:0] MODE_CONTINUE = 2'h2;
  localparam int MODE_SEL_LSB = 4;
  localparam int WRAP_LSB = 4;
  localparam int WRAP_DIS_POS = 0;
  localparam logic [2:0] WRAP_RST = 3'h7;
  localparam logic [7:0] WRAP_MIN_LEN = 8'h08;
  localparam logic [12:0] PAGE_LAST = 13'h00FF;
  localparam logic [12:0] SECTOR_LAST = 13'h0FFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_WEL_POS = 1;
  localparam int CLK_MHZ = 100;
  localparam int PROG_TIME_US = 400;
  localparam int ERASE_TIME_MS = 50;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 32;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_WRAP,
    ST_RDOUT, ST_STOUT, ST_PROG, ST_TAIL, ST_SKIP
  } sfp_state_e;

  typedef enum logic [1:0] {
    CM_IDLE, CM_FILL, CM_WAIT
  } sfp_commit_e;
endpackage : sfp_pkg

//--- core/sfp_flash_cmd.sv
// Serial flash command interpreter with its write FIFO.
`timescale 1ns/1ns
`default_nettype none

module sfp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic o_empty
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("FIFO depth must be a power of two");

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic push;
  logic pop;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign o_empty = (wr_ptr == rd_ptr);
  assign o_in_ready = ~full;
  assign o_out_valid = ~o_empty;
  assign o_out_data = mem[rd_ptr[AW-1:0]];
  assign push = i_in_valid & ~full;
  assign pop = i_out_ready & ~o_empty;

  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end
endmodule : sfp_fifo

module sfp_flash_cmd
  import sfp_pkg::*;
#(
  parameter int PROG_CYC = sfp_pkg::PROG_CYCLES,
  parameter int ERASE_CYC = sfp_pkg::ERASE_CYCLES,
  parameter int WBUF_DEPTH = sfp_pkg::FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_dq,
  output logic [3:0] o_dq,
  output logic [3:0] o_dq_oe,
  input wire logic i_quad_enable_bit,
  input wire logic i_target_locked,
  output logic [23:0] o_target_addr,
  output logic [23:0] o_mem_rd_addr,
  input wire logic [7:0] i_mem_rd_data,
  output logic o_mem_wr_valid,
  input wire logic i_mem_wr_ready,
  output logic [23:0] o_mem_wr_addr,
  output logic [7:0] o_mem_wr_data,
  output logic o_busy_flag,
  output logic o_write_enable_latch,
  output logic [2:0] o_wrap_config_bits,
  output logic o_continuous_read
);
  import sfp_pkg::*;

  if (PROG_CYC < 1 || ERASE_CYC < 1) $error("Cycle counts must be at least one");

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    sfp_state_e st;
    logic [7:0] cmd;
    logic [31:0] sr;
    logic [5:0] bits;
    logic [23:0] addr;
    logic nib;
    logic any;
    logic [5:0] extra;
    logic cont;
    logic [7:0] cont_cmd;
    logic [2:0] wrap;
    logic write_enable_latch;
    sfp_commit_e cm;
    logic erase;
    logic [12:0] iter;
    logic [31:0] tmr;
    logic [23:0] base;
    logic [255:0] valid;
    logic [3:0] dq;
    logic [3:0] oe;
  } sfp_state_s;

  sfp_state_s q;
  sfp_state_s next_q;
  logic [7:0] pbuf [256];
  logic buf_we;
  logic [7:0] buf_waddr;
  logic [7:0] buf_wdata;
  logic fifo_valid;
  logic fifo_ready;
  logic fifo_empty;
  logic [31:0] fifo_data;
  logic [31:0] fifo_out;

  function automatic logic is_quad(input logic [7:0] c);
    return (c == CMD_OCTAL_READ) || (c == CMD_QUAD_READ) || (c == CMD_WORD_READ) ||
           (c == CMD_WRAP_SET) || (c == CMD_QUAD_PROG);
  endfunction : is_quad

  function automatic logic is_read(input logic [7:0] c);
    return (c == CMD_OCTAL_READ) || (c == CMD_QUAD_READ) || (c == CMD_WORD_READ);
  endfunction : is_read

  function automatic logic [5:0] dummy_bits(input logic [7:0] c);
    logic [5:0] d;
    d = DUMMY_OCTAL_READ;
    if (c == CMD_QUAD_READ)
    begin
      d = DUMMY_QUAD_READ;
    end
    else if (c == CMD_WORD_READ)
    begin
      d = DUMMY_WORD_READ;
    end
    return d;
  endfunction : dummy_bits

  // The octal word read never wraps; only the other two quad reads honour the setting.
  function automatic logic [23:0] next_rd(input logic [23:0] a, input logic [7:0] c,
                                          input logic [2:0] w);
    logic [7:0] m;
    logic [7:0] inc;
    m = 8'((WRAP_MIN_LEN << w[2:1]) - 8'h01);
    inc = a[7:0] + 8'h01;
    if (c != CMD_OCTAL_READ && !w[WRAP_DIS_POS])
    begin
      return {a[23:8], (a[7:0] & ~m) | (inc & m)};
    end
    return a + 24'h000001;
  endfunction : next_rd

  always_comb
  begin
    logic rise;
    logic fall;
    logic cs_fall;
    logic cs_up;
    logic quad;
    logic busy;
    logic push;
    logic [3:0] din;
    logic [31:0] shifted;
    logic [5:0] nbits;
    logic [7:0] stat;
    logic [7:0] c;
    rise = 1'b0;
    fall = 1'b0;
    cs_fall = 1'b0;
    cs_up = 1'b0;
    quad = 1'b0;
    busy = 1'b0;
    push = 1'b0;
    din = '0;
    shifted = '0;
    nbits = '0;
    stat = '0;
    c = '0;
    next_q = q;
    buf_we = 1'b0;
    buf_waddr = q.addr[7:0];
    buf_wdata = '0;
    fifo_valid = 1'b0;
    fifo_data = '0;
    next_q.s1 = {i_cs_n, i_sclk, i_dq};
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    rise = q.s2[4] & ~q.s3[4];
    fall = ~q.s2[4] & q.s3[4];
    cs_fall = ~q.s2[5] & q.s3[5];
    cs_up = q.s2[5] & ~q.s3[5];
    din = q.s2[3:0];
    busy = (q.cm != CM_IDLE);
    stat[STAT_BUSY_POS] = busy;
    stat[STAT_WEL_POS] = q.write_enable_latch;
    quad = (q.st != ST_CMD) && is_quad(q.cmd);
    shifted = quad ? {q.sr[27:0], din} : {q.sr[30:0], din[0]};
    nbits = q.bits + (quad ? 6'h04 : 6'h01);
    c = shifted[7:0];

    if (cs_up)
    begin
      next_q.st = ST_IDLE;
      next_q.oe = 4'h0;
      if (q.st == ST_PROG && q.bits == 6'h00 && q.any && !i_target_locked)
      begin
        next_q.cm = CM_FILL;
        next_q.erase = 1'b0;
        next_q.base = {q.addr[23:8], 8'h00};
        next_q.iter = '0;
      end
      if (q.st == ST_TAIL && q.cmd == CMD_SECT_ERASE && q.extra == 6'h00 &&
          !i_target_locked)
      begin
        next_q.cm = CM_FILL;
        next_q.erase = 1'b1;
        next_q.base = {q.addr[23:12], 12'h000};
        next_q.iter = '0;
      end
      if (q.st == ST_TAIL && q.cmd == CMD_WRITE_ENABLE && q.extra == 6'h00)
      begin
        next_q.write_enable_latch = 1'b1;
      end
    end
    else if (cs_fall && q.st == ST_IDLE)
    begin
      next_q.bits = '0;
      next_q.nib = 1'b0;
      next_q.any = 1'b0;
      next_q.extra = '0;
      if (q.cont && !busy)
      begin
        next_q.st = ST_ADDR;
        next_q.cmd = q.cont_cmd;
      end
      else
      begin
        next_q.st = ST_CMD;
      end
    end
    else if (rise)
    begin
      next_q.sr = shifted;
      next_q.bits = nbits;
      case (q.st)
        ST_CMD:
        begin
          if (nbits == CMD_BITS)
          begin
            next_q.cmd = c;
            next_q.bits = '0;
            next_q.st = ST_SKIP;
            if (busy)
            begin
              if (c == CMD_STATUS_READ)
              begin
                next_q.st = ST_STOUT;
              end
            end
            else if (is_read(c))
            begin
              next_q.st = i_quad_enable_bit ? ST_ADDR : ST_SKIP;
            end
            else if (c == CMD_WRAP_SET)
            begin
              next_q.st = ST_WRAP;
            end
            else if (c == CMD_PAGE_PROG || c == CMD_SECT_ERASE)
            begin
              next_q.st = q.write_enable_latch ? ST_ADDR : ST_SKIP;
            end
            else if (c == CMD_QUAD_PROG)
            begin
              next_q.st = (q.write_enable_latch && i_quad_enable_bit) ? ST_ADDR : ST_SKIP;
            end
            else if (c == CMD_STATUS_READ)
            begin
              next_q.st = ST_STOUT;
            end
            else if (c == CMD_WRITE_ENABLE)
            begin
              next_q.st = ST_TAIL;
            end
          end
        end
        ST_ADDR:
        begin
          if (nbits == ADDR_BITS)
          begin
            next_q.addr = shifted[23:0];
            next_q.bits = '0;
            if (is_read(q.cmd))
            begin
              next_q.st = ST_MODE;
            end
            else if (q.cmd == CMD_SECT_ERASE)
            begin
              next_q.st = ST_TAIL;
            end
            else
            begin
              next_q.st = ST_PROG;
              next_q.valid = '0;
            end
          end
        end
        ST_MODE:
        begin
          if (nbits == MODE_BITS)
          begin
            next_q.bits = '0;
            // The low nibble of the mode byte is never looked at.
            next_q.cont = (shifted[MODE_SEL_LSB+1:MODE_SEL_LSB] == MODE_CONTINUE);
            next_q.cont_cmd = q.cmd;
            next_q.st = (dummy_bits(q.cmd) == 6'h00) ? ST_RDOUT : ST_DUMMY;
          end
        end
        ST_DUMMY:
        begin
          if (nbits == dummy_bits(q.cmd))
          begin
            next_q.st = ST_RDOUT;
            next_q.bits = '0;
          end
        end
        ST_WRAP:
        begin
          if (nbits == WRAP_FRAME_BITS)
          begin
            next_q.wrap = shifted[WRAP_LSB+2:WRAP_LSB];
            next_q.st = ST_SKIP;
          end
        end
        ST_PROG:
        begin
          if (nbits == BYTE_BITS)
          begin
            buf_we = 1'b1;
            buf_wdata = shifted[7:0];
            next_q.valid[q.addr[7:0]] = 1'b1;
            next_q.addr = {q.addr[23:8], q.addr[7:0] + 8'h01};
            next_q.any = 1'b1;
            next_q.bits = '0;
          end
        end
        ST_TAIL:
        begin
          // Any clock after the last expected byte voids the instruction.
          next_q.extra = (q.extra == 6'h3F) ? q.extra : q.extra + 6'h01;
        end
        default:
        begin
          next_q.bits = q.bits;
        end
      endcase
    end
    else if (fall)
    begin
      if (q.st == ST_RDOUT)
      begin
        next_q.oe = 4'hF;
        next_q.dq = q.nib ? i_mem_rd_data[3:0] : i_mem_rd_data[7:4];
        next_q.nib = ~q.nib;
        if (q.nib)
        begin
          next_q.addr = next_rd(q.addr, q.cmd, q.wrap);
        end
      end
      else if (q.st == ST_STOUT)
      begin
        // Status goes out live, so a polling host sees busy drop mid-transfer.
        next_q.oe = 4'h2;
        next_q.dq = {2'b00, stat[3'h7 - q.bits[2:0]], 1'b0};
        next_q.bits = q.bits + 6'h01;
      end
    end

    case (q.cm)
      CM_FILL:
      begin
        push = q.erase | q.valid[q.iter[7:0]];
        fifo_valid = push;
        if (q.erase)
        begin
          fifo_data = {q.base | {12'h000, q.iter[11:0]}, ERASED_BYTE};
        end
        else
        begin
          fifo_data = {q.base | {16'h0000, q.iter[7:0]}, pbuf[q.iter[7:0]]};
        end
        if (!push || fifo_ready)
        begin
          next_q.iter = q.iter + 13'h0001;
          if (q.iter == (q.erase ? SECTOR_LAST : PAGE_LAST))
          begin
            next_q.cm = CM_WAIT;
            next_q.tmr = '0;
          end
        end
      end
      CM_WAIT:
      begin
        next_q.tmr = q.tmr + 32'h00000001;
        if (fifo_empty && q.tmr >= 32'(q.erase ? ERASE_CYC - 1 : PROG_CYC - 1))
        begin
          next_q.cm = CM_IDLE;
          next_q.write_enable_latch = 1'b0;
        end
      end
      default:
      begin
        // The iterator is left untouched here; a fresh cycle zeroes it when select rises.
        next_q.tmr = q.tmr;
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (buf_we)
    begin
      pbuf[buf_waddr] <= buf_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      q <= '0;
      // Idle pin levels: select high, serial clock low, so no false edge follows reset.
      q.s1 <= 6'h20;
      q.s2 <= 6'h20;
      q.s3 <= 6'h20;
      q.st <= ST_IDLE;
      q.cm <= CM_IDLE;
      q.wrap <= WRAP_RST;
    end
    else
    begin
      q <= next_q;
    end
  end

  sfp_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(WBUF_DEPTH)
  ) u_wr_fifo (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_in_valid(fifo_valid),
    .o_in_ready(fifo_ready),
    .i_in_data(fifo_data),
    .o_out_valid(o_mem_wr_valid),
    .i_out_ready(i_mem_wr_ready),
    .o_out_data(fifo_out),
    .o_empty(fifo_empty)
  );

  assign o_mem_wr_addr = fifo_out[31:8];
  assign o_mem_wr_data = fifo_out[7:0];
  assign o_dq = q.dq;
  assign o_dq_oe = q.oe;
  assign o_target_addr = q.addr;
  assign o_mem_rd_addr = q.addr;
  assign o_busy_flag = (q.cm != CM_IDLE);
  assign o_write_enable_latch = q.write_enable_latch;
  assign o_wrap_config_bits = q.wrap;
  assign o_continuous_read = q.cont;
endmodule : sfp_flash_cmd

`default_nettype wire

//--- dv/sfp_host_model.sv
// Host controller model that drives select, serial clock and data lines.
`timescale 1ns/1ns
`default_nettype none

module sfp_host_model (
  input wire logic i_mclk,
  input wire logic [3:0] i_dq,
  output logic o_cs_n,
  output logic o_sclk,
  output logic [3:0] o_dq
);
  // Pin edges sit 2, 3, 7 or 8 ns off the clock grid, so none lands on a sampling edge.
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_dq = 4'h0;
  end

  task automatic open_t();
    @(negedge i_mclk);
    #7 o_cs_n = 1'b0;
  endtask : open_t

  // Select rises only after the last full clock of the frame.
  task automatic close_t();
    #20 o_cs_n = 1'b1;
    o_dq = ~o_dq;
    #100;
  endtask : close_t

  task automatic send(input logic [31:0] v, input int clks, input logic quad);
    for (int i = clks - 1; i >= 0; i--)
    begin
      o_dq = quad ? v[i*4+:4] : {~o_dq[3:1], v[i]};
      #61 o_sclk = 1'b1;
      #64 o_sclk = 1'b0;
    end
  endtask : send

  task automatic recv(input int clks, input logic quad, output logic [31:0] r);
    r = '0;
    for (int i = 0; i < clks; i++)
    begin
      // A released line churns, so stale host data can never pass for read data.
      o_dq = ~o_dq;
      #61 o_sclk = 1'b1;
      r = quad ? {r[27:0], i_dq} : {r[30:0], i_dq[1]};
      #64 o_sclk = 1'b0;
    end
  endtask : recv

  task automatic exit_cont();
    open_t();
    send(32'hFF, 8, 1'b0);
    close_t();
  endtask : exit_cont
endmodule : sfp_host_model

`default_nettype wire

//--- dv/sfp_flash_cmd_sva.sv
// Concurrent checks on the ports of the flash command interpreter.
`timescale 1ns/1ns
`default_nettype none

module sfp_flash_cmd_sva (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_quad_enable_bit,
  input wire logic o_mem_wr_valid,
  input wire logic i_mem_wr_ready,
  input wire logic [23:0] o_mem_wr_addr,
  input wire logic [7:0] o_mem_wr_data,
  input wire logic o_busy_flag,
  input wire logic o_write_enable_latch,
  input wire logic [2:0] o_wrap_config_bits,
  input wire logic o_continuous_read
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  reset_values_a: assert property ($rose(i_arst_n) |-> o_wrap_config_bits == 3'h7
    && !o_busy_flag && !o_write_enable_latch && !o_continuous_read) else $error("reset values");
  wel_clear_a: assert property ($fell(o_write_enable_latch) |-> $fell(o_busy_flag))
    else $error("latch cleared outside cycle end");
  busy_end_a: assert property ($fell(o_busy_flag) |-> !o_write_enable_latch
    && !o_mem_wr_valid) else $error("cycle end state");
  busy_start_a: assert property ($rose(o_busy_flag) |-> $past(o_write_enable_latch)
    && i_cs_n) else $error("cycle without latch");
  wrap_frozen_a: assert property ($changed(o_wrap_config_bits) |-> !$past(o_busy_flag))
    else $error("wrap changed while busy");
  write_in_cycle_a: assert property (o_mem_wr_valid |-> o_busy_flag)
    else $error("write outside cycle");
  write_hold_a: assert property (o_mem_wr_valid && !i_mem_wr_ready |=> o_mem_wr_valid
    && $stable(o_mem_wr_addr) && $stable(o_mem_wr_data)) else $error("write dropped");
  cont_quad_a: assert property ($rose(o_continuous_read) |-> i_quad_enable_bit)
    else $error("continuous without quad");

  busy_c: cover property ($rose(o_busy_flag));
  cont_c: cover property ($rose(o_continuous_read));
  stall_c: cover property (o_mem_wr_valid && !i_mem_wr_ready);
endmodule : sfp_flash_cmd_sva

bind sfp_flash_cmd sfp_flash_cmd_sva u_sva (
  .i_mclk(i_mclk),
  .i_arst_n(i_arst_n),
  .i_cs_n(i_cs_n),
  .i_quad_enable_bit(i_quad_enable_bit),
  .o_mem_wr_valid(o_mem_wr_valid),
  .i_mem_wr_ready(i_mem_wr_ready),
  .o_mem_wr_addr(o_mem_wr_addr),
  .o_mem_wr_data(o_mem_wr_data),
  .o_busy_flag(o_busy_flag),
  .o_write_enable_latch(o_write_enable_latch),
  .o_wrap_config_bits(o_wrap_config_bits),
  .o_continuous_read(o_continuous_read)
);

`default_nettype wire

//--- dv/sfp_flash_cmd_tb_top.sv
// Self-checking bench for the flash command interpreter.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end

module sfp_flash_cmd_tb_top;
  import sfp_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic qe = 1'b1;
  logic locked = 1'b0;
  logic ready = 1'b1;
  logic cs_n, sclk, wr_valid, busy, write_enable_latch, cont;
  logic [3:0] h_dq, d_dq, d_oe, dq_w;
  logic [23:0] rd_addr, wr_addr, la, tgt;
  logic [7:0] wr_data;
  logic [2:0] wrap;
  logic [31:0] r;
  logic [23:0] wa [0:7];
  logic [7:0] wd [0:7];
  int wr_n = 0;
  int ff_n = 0;
  int oe_n = 0;
  int cyc = 0;
  int failures = 0;
  int check_count = 0;

  always #5 mclk = ~mclk;
  assign dq_w = (d_oe & d_dq) | (~d_oe & h_dq);

  sfp_host_model u_host (.i_mclk(mclk), .i_dq(dq_w), .o_cs_n(cs_n), .o_sclk(sclk), .o_dq(h_dq));

  sfp_flash_cmd #(.PROG_CYC(1000), .ERASE_CYC(5000), .WBUF_DEPTH(32)) DUT (
    .i_mclk(mclk), .i_arst_n(arst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_dq(dq_w),
    .o_dq(d_dq), .o_dq_oe(d_oe), .i_quad_enable_bit(qe), .i_target_locked(locked),
    .o_target_addr(tgt), .o_mem_rd_addr(rd_addr), .i_mem_rd_data(rd_addr[7:0] ^ 8'h5A),
    .o_mem_wr_valid(wr_valid), .i_mem_wr_ready(ready), .o_mem_wr_addr(wr_addr),
    .o_mem_wr_data(wr_data), .o_busy_flag(busy), .o_write_enable_latch(write_enable_latch),
    .o_wrap_config_bits(wrap), .o_continuous_read(cont));

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (d_oe != 4'h0)
      oe_n <= oe_n + 1;
    if (wr_valid && ready)
    begin
      if (wr_n < 8)
      begin
        wa[wr_n] <= wr_addr;
        wd[wr_n] <= wr_data;
      end
      la <= wr_addr;
      wr_n <= wr_n + 1;
      ff_n <= ff_n + int'(wr_data == 8'hFF);
    end
    if (cyc == 80000)
    begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic cmd(input logic [7:0] c);
    u_host.open_t();
    u_host.send(c, 8, 1'b0);
  endtask : cmd

  task automatic tx(input logic [7:0] c, input logic [31:0] a, input int an, input logic aq,
                    input logic [31:0] d, input int dn, input logic dqq);
    cmd(c);
    u_host.send(a, an, aq);
    u_host.send(d, dn, dqq);
    u_host.close_t();
  endtask : tx

  task automatic stat(output logic [7:0] s);
    cmd(CMD_STATUS_READ);
    u_host.recv(8, 1'b0, r);
    u_host.close_t();
    s = r[7:0];
  endtask : stat

  // Status reads keep working during the cycle, so polling them is the wait.
  task automatic wait_idle();
    logic [7:0] s;
    for (int i = 0; i < 200; i++)
    begin
      stat(s);
      if (s[0] === 1'b0)
        break;
    end
  endtask : wait_idle

  initial
  begin
    logic [7:0] s;
    int b;
    repeat (16) @(posedge mclk);
    @(negedge mclk) arst_n = 1'b1;
    #100;
    `CHK("wrap_rst", 3'h7, wrap)
    cmd(CMD_OCTAL_READ);
    u_host.send(24'h000120, 6, 1'b1);
    u_host.send(8'hA5, 2, 1'b1);
    u_host.recv(4, 1'b1, r);
    u_host.close_t();
    `CHK("octal_rd", 16'h7A7B, r[15:0])
    `CHK("cont_on", 1'b1, cont)
    u_host.open_t();
    u_host.send(24'h000240, 6, 1'b1);
    u_host.send(8'h2F, 2, 1'b1);
    u_host.recv(2, 1'b1, r);
    u_host.close_t();
    `CHK("cont_rd", 8'h1A, r[7:0])
    `CHK("cont_keep", 1'b1, cont)
    u_host.exit_cont();
    `CHK("cont_off", 1'b0, cont)
    @(negedge mclk) qe = 1'b0;
    b = oe_n;
    tx(CMD_OCTAL_READ, 24'h000120, 6, 1'b1, 8'hA5, 2, 1'b1);
    `CHK("qe_off_oe", b, oe_n)
    `CHK("qe_off_cont", 1'b0, cont)
    @(negedge mclk) qe = 1'b1;
    tx(CMD_WRAP_SET, 0, 6, 1'b1, 8'hCA, 2, 1'b1);
    `CHK("wrap_cfg", 3'h4, wrap)
    cmd(CMD_QUAD_READ);
    u_host.send(24'h00013E, 6, 1'b1);
    u_host.send(0, 6, 1'b1);
    u_host.recv(6, 1'b1, r);
    u_host.close_t();
    `CHK("wrap_rd", 24'h64657A, r[23:0])
    tx(CMD_WRAP_SET, 0, 6, 1'b1, 8'h10, 2, 1'b1);
    `CHK("wrap_off", 3'h1, wrap)
    tx(CMD_PAGE_PROG, 24'h000010, 24, 1'b0, 8'h55, 8, 1'b0);
    `CHK("pp_nowel", 0, wr_n)
    tx(CMD_WRITE_ENABLE, 0, 0, 1'b0, 0, 0, 1'b0);
    stat(s);
    `CHK("wel_set", 2'h2, s[1:0])
    tx(CMD_PAGE_PROG, 24'h0000FE, 24, 1'b0, 24'h112233, 24, 1'b0);
    stat(s);
    `CHK("pp_busy", 1'b1, s[0])
    wait_idle();
    stat(s);
    `CHK("pp_wel", 2'h0, s[1:0])
    `CHK("pp_n", 3, wr_n)
    `CHK("pp_w0", 32'h00000033, {wa[0], wd[0]})
    `CHK("pp_w1", 32'h0000FE11, {wa[1], wd[1]})
    `CHK("pp_w2", 32'h0000FF22, {wa[2], wd[2]})
    tx(CMD_WRITE_ENABLE, 0, 0, 1'b0, 0, 0, 1'b0);
    tx(CMD_PAGE_PROG, 24'h000010, 24, 1'b0, 12'h550, 12, 1'b0);
    `CHK("pp_part", 3, wr_n)
    @(negedge mclk) qe = 1'b0;
    tx(CMD_QUAD_PROG, 24'h000310, 6, 1'b1, 8'h44, 2, 1'b1);
    `CHK("qp_noqe", 3, wr_n)
    @(negedge mclk) qe = 1'b1;
    tx(CMD_QUAD_PROG, 24'h000310, 6, 1'b1, 8'h44, 2, 1'b1);
    wait_idle();
    `CHK("qp_w3", 32'h00031044, {wa[3], wd[3]})
    tx(CMD_WRITE_ENABLE, 0, 0, 1'b0, 0, 0, 1'b0);
    @(negedge mclk) locked = 1'b1;
    tx(CMD_SECT_ERASE, 24'h012345, 24, 1'b0, 0, 0, 1'b0);
    `CHK("lock_addr", 24'h012345, tgt)
    @(negedge mclk) locked = 1'b0;
    stat(s);
    `CHK("lock_idle", 2'h2, s[1:0])
    b = wr_n;
    tx(CMD_SECT_ERASE, 24'h012345, 24, 1'b0, 0, 0, 1'b0);
    @(negedge mclk) ready = 1'b0;
    tx(CMD_WRAP_SET, 0, 6, 1'b1, 8'h00, 2, 1'b1);
    `CHK("busy_ignore", 3'h1, wrap)
    repeat (100) @(negedge mclk);
    ready = 1'b1;
    wait_idle();
    `CHK("er_n", b + 4096, wr_n)
    `CHK("er_ff", 4096, ff_n)
    `CHK("er_last", 24'h012FFF, la)
    stat(s);
    `CHK("er_wel", 2'h0, s[1:0])
    close_out();
  end
endmodule : sfp_flash_cmd_tb_top

`default_nettype wire
